// File: rtl/pmf_map.vh
// Constants of the program memory fetch port
// Operation
// - Drive twelve-line address; top line reserved
// - Take instruction bytes on eight-bit input bus
// - Fetch strobe low during low-2K fetches
// - Fetch strobe high on other reads
// - Sync low one clock before opcode fetch
// - System clock out at half crystal rate
// - Interrupt acknowledge high during interrupt cycle; here registered, so it rises and falls one clock after intr_cycle
`ifndef PMF_MAP_VH
`define PMF_MAP_VH
`define PMF_ADDR_W 12
`define PMF_DATA_W 8
`define PMF_LOW_LIMIT 12'h800
`define PMF_RESERVED_BIT 11
`define PMF_FETCH_CYCLES 3'h3
`define PMF_ST_IDLE 2'h0
`define PMF_ST_SYNC 2'h1
`define PMF_ST_FETCH 2'h2
`define PMF_ST_OTHER 2'h3
`define PMF_RST_CNT 3'h0
`define PMF_RST_LOW 1'b0
`define PMF_RST_DONE 1'b0
`define PMF_RST_BYTE 8'h00
`define PMF_RST_ADDR 12'h000
`define PMF_RST_STROBE_N 1'b1
`define PMF_RST_SYNC_N 1'b1
`define PMF_RST_SCLK 1'b0
`define PMF_RST_INTERRUPT_ACKNOWLEDGE_OUT 1'b0
`endif

// File: rtl/pmf_fetch_port.v
// Program memory fetch port with sync, clock and acknowledge outputs
`timescale 1ns/1ns
`include "pmf_map.vh"
module pmf_fetch_port #(
  parameter FETCH_CYCLES = `PMF_FETCH_CYCLES
) (
  input wire mclk,
  input wire sys_rst,
  input wire fetch_req,
  input wire opcode_fetch,
  input wire [11:0] fetch_addr,
  input wire intr_cycle,
  input wire [7:0] program_data_in,
  output wire fetch_busy,
  output wire fetch_done,
  output wire [7:0] fetch_byte,
  output wire [11:0] program_address_out,
  output wire program_fetch_strobe_n,
  output wire sync_n,
  output wire sys_clk_out,
  output wire interrupt_acknowledge_out
);
  localparam ST_IDLE = `PMF_ST_IDLE;
  localparam ST_SYNC = `PMF_ST_SYNC;
  localparam ST_FETCH = `PMF_ST_FETCH;
  localparam ST_OTHER = `PMF_ST_OTHER;
  // Counter is three bits wide, so FETCH_CYCLES must stay between 1 and 8
  localparam [2:0] LAST_CNT = FETCH_CYCLES[2:0] - 3'h1;

  // Sequencer state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg low_q;
  reg low_d;
  // Output registers
  reg done_q;
  reg done_d;
  reg [7:0] byte_q;
  reg [7:0] byte_d;
  reg [11:0] addr_q;
  reg [11:0] addr_d;
  reg strobe_n_q;
  reg strobe_n_d;
  reg sync_n_q;
  reg sync_n_d;
  reg sclk_q;
  reg sclk_d;
  reg interrupt_acknowledge_out_q;
  reg interrupt_acknowledge_out_d;
  // Pin synchroniser for the data bus
  reg [7:0] data_s1_q;
  reg [7:0] data_s2_q;
  wire last;

  // Only the lowest 2K of program space is reached through the strobe
  function in_low_region;
    input [11:0] addr;
    begin
      in_low_region = (addr < `PMF_LOW_LIMIT);
    end
  endfunction

  // Reserved top line is forced low so the far side never sees it move
  function [11:0] drive_addr;
    input [11:0] addr;
    begin
      drive_addr = addr;
      drive_addr[`PMF_RESERVED_BIT] = 1'b0;
    end
  endfunction

  // Both read kinds share the same wait counter
  function [2:0] next_cnt;
    input [2:0] cnt;
    begin
      next_cnt = cnt + 3'h1;
    end
  endfunction

  assign last = (cnt_q == LAST_CNT);
  assign fetch_busy = (state_q != ST_IDLE);
  assign fetch_done = done_q;
  assign fetch_byte = byte_q;
  assign program_address_out = addr_q;
  assign program_fetch_strobe_n = strobe_n_q;
  assign sync_n = sync_n_q;
  assign sys_clk_out = sclk_q;
  assign interrupt_acknowledge_out = interrupt_acknowledge_out_q;

  // Data bus comes from outside; two stages before use
  always @(posedge mclk) begin
    if (sys_rst) begin
      data_s1_q <= `PMF_RST_BYTE;
      data_s2_q <= `PMF_RST_BYTE;
    end else begin
      data_s1_q <= program_data_in;
      data_s2_q <= data_s1_q;
    end
  end

  // Free-running divide by two of the core clock
  always @* begin
    sclk_d = ~sclk_q;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      sclk_q <= `PMF_RST_SCLK;
    end else begin
      sclk_q <= sclk_d;
    end
  end

  // Acknowledge follows the core's interrupt cycle one clock late
  always @* begin
    interrupt_acknowledge_out_d = intr_cycle;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      interrupt_acknowledge_out_q <= `PMF_RST_INTERRUPT_ACKNOWLEDGE_OUT;
    end else begin
      interrupt_acknowledge_out_q <= interrupt_acknowledge_out_d;
    end
  end

  // Next-state logic of the fetch sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    low_d = low_q;
    done_d = 1'b0;
    byte_d = byte_q;
    addr_d = addr_q;
    strobe_n_d = strobe_n_q;
    sync_n_d = sync_n_q;
    case (state_q)
      ST_IDLE: begin
        if (fetch_req) begin
          addr_d = drive_addr(fetch_addr);
          low_d = in_low_region(fetch_addr);
          cnt_d = `PMF_RST_CNT;
          if (opcode_fetch) begin
            sync_n_d = 1'b0;
            state_d = ST_SYNC;
          end else begin
            state_d = ST_OTHER;
          end
        end
      end
      ST_SYNC: begin
        sync_n_d = 1'b1;
        strobe_n_d = ~low_q;
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        cnt_d = next_cnt(cnt_q);
        // Taken from the synchronised bus, so memory must drive the byte
        // by the clock edge two cycles before the strobe rises
        if (last) begin
          byte_d = data_s2_q;
          done_d = 1'b1;
          strobe_n_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_OTHER: begin
        cnt_d = next_cnt(cnt_q);
        if (last) begin
          byte_d = data_s2_q;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        strobe_n_d = `PMF_RST_STROBE_N;
        sync_n_d = `PMF_RST_SYNC_N;
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= `PMF_RST_CNT;
      low_q <= `PMF_RST_LOW;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      done_q <= `PMF_RST_DONE;
      byte_q <= `PMF_RST_BYTE;
      addr_q <= `PMF_RST_ADDR;
    end else begin
      done_q <= done_d;
      byte_q <= byte_d;
      addr_q <= addr_d;
    end
  end

  // Strobes idle high so a reset mid-fetch releases the memory on the next mclk edge
  always @(posedge mclk) begin
    if (sys_rst) begin
      strobe_n_q <= `PMF_RST_STROBE_N;
      sync_n_q <= `PMF_RST_SYNC_N;
    end else begin
      strobe_n_q <= strobe_n_d;
      sync_n_q <= sync_n_d;
    end
  end
endmodule

// File: test/pmf_fetch_port_assertions.sv
// Fetch port timing checker
`timescale 1ns/1ns
module pmf_chk (
  input wire mclk,
  input wire sys_rst,
  input wire fetch_req,
  input wire fetch_busy,
  input wire opcode_fetch,
  input wire intr_cycle,
  input wire sys_clk_out,
  input wire [11:0] fetch_addr,
  input wire [11:0] program_address_out,
  input wire program_fetch_strobe_n,
  input wire sync_n,
  input wire interrupt_acknowledge_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_go;
    fetch_req && !fetch_busy;
  endsequence
  // Strobe low for the three wait cycles, then released
  sequence s_strobe_low;
    !program_fetch_strobe_n [*3] ##1 program_fetch_strobe_n;
  endsequence
  property p_f;
    s_go ##0 opcode_fetch && fetch_addr < 12'h800 |=> !sync_n ##1 s_strobe_low;
  endproperty
  a_f: assert property (p_f) else $error("fetch");
  property p_o;
    s_go ##0 !opcode_fetch |=> program_fetch_strobe_n [*4];
  endproperty
  a_o: assert property (p_o) else $error("read");
  property p_h;
    s_go ##0 opcode_fetch && fetch_addr[11] |=> program_fetch_strobe_n [*4];
  endproperty
  a_h: assert property (p_h) else $error("upper fetch");
  property p_s;
    !sync_n |=> sync_n;
  endproperty
  a_s: assert property (p_s) else $error("sync width");
  property p_a;
    !program_address_out[11];
  endproperty
  a_a: assert property (p_a) else $error("reserved address line");
  property p_c;
    !sys_rst |=> sys_clk_out != $past(sys_clk_out);
  endproperty
  a_c: assert property (p_c) else $error("system clock");
  property p_k;
    !sys_rst |=> interrupt_acknowledge_out == $past(intr_cycle);
  endproperty
  a_k: assert property (p_k) else $error("interrupt acknowledge");
endmodule
bind pmf_fetch_port pmf_chk CHK (.*);

// File: test/pmf_prog_mem.sv
// Program memory model
`timescale 1ns/1ns
module pmf_prog_mem (
  input wire [11:0] program_address_out,
  input wire program_fetch_strobe_n,
  output wire [7:0] program_data_in
);
  reg [7:0] q = 8'h00;
  always @* if (!program_fetch_strobe_n) q = program_address_out[7:0] ^ 8'h5a;
  // Bus released when not strobed: show a changed value, not the old byte
  assign program_data_in = program_fetch_strobe_n ? ~q : q;
endmodule

// File: test/pmf_fetch_port_tb_top.sv
// Fetch port testbench
`timescale 1ns/1ns
`include "pmf_map.vh"
`define CHK(n,e,s) begin \
  checked++; \
  if ((s) !== (e)) begin \
    failures++; \
    $display("BAD %s %h %h", n, e, s); \
  end \
end
module pmf_fetch_port_tb_top;
  reg mclk = 0, sys_rst = 1, fetch_req = 0, opcode_fetch = 0, intr_cycle = 0;
  reg [11:0] fetch_addr = 12'h000;
  wire [11:0] program_address_out;
  wire [7:0] program_data_in, fetch_byte;
  wire program_fetch_strobe_n, fetch_busy, fetch_done, interrupt_acknowledge_out;
  wire sync_n, sys_clk_out;
  int failures = 0, checked = 0, cyc = 0;
  pmf_prog_mem MEM (
    .program_address_out(program_address_out),
    .program_fetch_strobe_n(program_fetch_strobe_n),
    .program_data_in(program_data_in)
  );
  pmf_fetch_port DUT (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fetch_req(fetch_req),
    .opcode_fetch(opcode_fetch),
    .fetch_addr(fetch_addr),
    .intr_cycle(intr_cycle),
    .program_data_in(program_data_in),
    .fetch_busy(fetch_busy),
    .fetch_done(fetch_done),
    .fetch_byte(fetch_byte),
    .program_address_out(program_address_out),
    .program_fetch_strobe_n(program_fetch_strobe_n),
    .sync_n(sync_n),
    .sys_clk_out(sys_clk_out),
    .interrupt_acknowledge_out(interrupt_acknowledge_out)
  );
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 500) begin failures++; stop_test; end
  task stop_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One read; a second request while busy must be ignored
  task t_fetch(input logic o, input logic [11:0] a);
    int k;
    int nsync;
    int nlow;
    k = 0;
    nlow = 0;
    fetch_req = 1;
    opcode_fetch = o;
    fetch_addr = a;
    @(posedge mclk) #1 fetch_addr = ~a;
    `CHK("busy", 1'b1, fetch_busy)
    nsync = (sync_n === 1'b0);
    @(posedge mclk) #1 fetch_req = 0;
    while (k < 9 && fetch_done !== 1'b1) begin
      nsync += (sync_n === 1'b0);
      nlow += (program_fetch_strobe_n === 1'b0);
      k++;
      @(posedge mclk) #1;
    end
    `CHK("done", 1'b1, fetch_done)
    `CHK("idle", 1'b0, fetch_busy)
    `CHK("addr", {1'b0, a[10:0]}, program_address_out)
    `CHK("sync_cycles", o ? 1 : 0, nsync)
    `CHK("strobe_cycles", (o && !a[11]) ? `PMF_FETCH_CYCLES : 0, nlow)
    `CHK("strobe_end", 1'b1, program_fetch_strobe_n)
    if (o && !a[11]) `CHK("byte", a[7:0] ^ 8'h5a, fetch_byte)
  endtask
  task t_clk;
    logic v;
    @(posedge mclk) #1 v = sys_clk_out;
    @(posedge mclk) #1 `CHK("sys_clk", 1'b1, (v !== 1'bx) && (sys_clk_out === ~v))
  endtask
  task t_ack;
    intr_cycle = 1;
    @(posedge mclk) #1 `CHK("intr_ack", 1'b1, interrupt_acknowledge_out)
    intr_cycle = 0;
    @(posedge mclk) #1 `CHK("intr_ack_end", 1'b0, interrupt_acknowledge_out)
  endtask
  task t_reset;
    sys_rst = 1;
    repeat (2) @(posedge mclk);
    #1 `CHK("rst_strobe", 1'b1, program_fetch_strobe_n)
    `CHK("rst_sync", 1'b1, sync_n)
    `CHK("rst_busy", 1'b0, fetch_busy)
    sys_rst = 0;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 sys_rst = 0;
    t_fetch(1, 12'h7ff);
    t_fetch(0, 12'h045);
    t_fetch(1, 12'hfff);
    t_clk;
    t_ack;
    t_reset;
    t_fetch(1, 12'h123);
    stop_test;
  end
endmodule
